// ==== common/fhp_pkg.sv ====
// Shared constants and carriers for the host bus and DMA port.
package fhp_pkg;

  // Widths of the host data bus and the local register address.
  localparam int FHP_DATA_W = 8;
  localparam int FHP_ADDR_W = 3;

  // Values that state takes after reset.
  localparam logic [1:0] FHP_SYNC_RST   = 2'h0;
  localparam logic       FHP_STROBE_IDL = 1'h1;
  localparam logic       FHP_OE_N_RST   = 1'h1;
  localparam logic       FHP_BIT_RST    = 1'h0;
  localparam logic [7:0] FHP_DATA_RST   = 8'h00;
  localparam logic [2:0] FHP_ADDR_RST   = 3'h0;

  // Positions of the strobes inside the edge detector vector.
  localparam int FHP_EDGE_RD   = 0;
  localparam int FHP_EDGE_WR   = 1;
  localparam int FHP_EDGE_DACK = 2;
  localparam int FHP_EDGE_N    = 3;

  // Kind of write cycle remembered between the strobe's two edges.
  localparam logic [1:0] FHP_WR_NONE = 2'h0;
  localparam logic [1:0] FHP_WR_REG  = 2'h1;
  localparam logic [1:0] FHP_WR_DMA  = 2'h2;

  // One register access toward the controller core.
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [FHP_ADDR_W-1:0] addr;
    logic [FHP_DATA_W-1:0] wdata;
  } fhp_reg_req_t;

  // One DMA byte move and the terminal count toward the core.
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic                  tc;
    logic [FHP_DATA_W-1:0] wdata;
  } fhp_dma_xfer_t;

  localparam fhp_reg_req_t  FHP_REG_REQ_RST  = '0;
  localparam fhp_dma_xfer_t FHP_DMA_XFER_RST = '0;

  // States of the DMA request handshake.
  typedef enum logic [2:0] {
    FHP_DRQ_IDLE = 3'h1,
    FHP_DRQ_ASK  = 3'h2,
    FHP_DRQ_HOLD = 3'h4
  } fhp_drq_state_t;

endpackage

// ==== hdl/fhp_dma_ctrl.sv ====
`timescale 1ns/1ps
// DMA request handshake and terminal count qualification.
module fhp_dma_ctrl (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic op_rst_in,
  input  wire logic need_in,
  input  wire logic last_in,
  input  wire logic grant_n_in,
  input  wire logic grant_fall_in,
  input  wire logic rd_fall_in,
  input  wire logic tc_in,
  output logic      drq_out,
  output logic      tc_pulse_out
);
  import fhp_pkg::*;

  fhp_drq_state_t state_r;
  fhp_drq_state_t state_nxt;
  logic           clear_c;
  logic           tc_prev_r;

  // The last byte drops the request on the grant's fall, or on the read fall in demand mode.
  assign clear_c = last_in & (grant_fall_in | (~grant_n_in & rd_fall_in));

  // Next state: ask while the core needs a byte, hold off after the last one.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FHP_DRQ_IDLE: begin
        if (need_in) begin
          state_nxt = FHP_DRQ_ASK;
        end
      end
      FHP_DRQ_ASK: begin
        if (clear_c) begin
          state_nxt = FHP_DRQ_HOLD;
        end else if (!need_in) begin
          state_nxt = FHP_DRQ_IDLE;
        end
      end
      FHP_DRQ_HOLD: begin
        if (!need_in) begin
          state_nxt = FHP_DRQ_IDLE;
        end
      end
      default: begin
        state_nxt = FHP_DRQ_IDLE;
      end
    endcase
    if (op_rst_in) begin
      state_nxt = FHP_DRQ_IDLE;
    end
  end

  // State and request flop; the request mirrors the asking state.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= FHP_DRQ_IDLE;
      drq_out <= FHP_BIT_RST;
    end else begin
      state_r <= state_nxt;
      drq_out <= (state_nxt == FHP_DRQ_ASK);
    end
  end

  // Terminal count is accepted on its rise only while the grant is low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tc_prev_r    <= FHP_BIT_RST;
      tc_pulse_out <= FHP_BIT_RST;
    end else begin
      tc_prev_r    <= tc_in;
      tc_pulse_out <= tc_in & ~tc_prev_r & ~grant_n_in & ~op_rst_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_DRQ_SET: assert property (
    (state_r == FHP_DRQ_IDLE) && need_in && !op_rst_in |=> drq_out
  ) else $error("request not raised for a needed byte");

  AST_DRQ_CLEAR: assert property (
    drq_out && clear_c && !op_rst_in |=> !drq_out ##1 !drq_out || !need_in
  ) else $error("request not dropped on the last byte");

  AST_TC_GATED: assert property (
    tc_pulse_out |-> $past(!grant_n_in) && $past(tc_in)
  ) else $error("terminal count passed without a grant");

  COV_LAST_BYTE: cover property (drq_out && clear_c);

endmodule

// ==== hdl/fhp_edge_det.sv ====
`timescale 1ns/1ps
// Leading and trailing edge detector for a vector of active-low strobes.
module fhp_edge_det #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] sig_n_in,
  output logic      [WIDTH-1:0] fall_out,
  output logic      [WIDTH-1:0] rise_out
);
  import fhp_pkg::*;

  // Refuse an empty vector.
  if (WIDTH < 1) begin : g_chk
    $error("fhp_edge_det needs WIDTH of at least one");
  end

  // One previous-value flop and two edge terms per strobe.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic prev_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        prev_r <= FHP_STROBE_IDL;
      end else begin
        prev_r <= sig_n_in[i];
      end
    end
    assign fall_out[i] = prev_r & ~sig_n_in[i];
    assign rise_out[i] = ~prev_r & sig_n_in[i];
  end

endmodule

// ==== hdl/fhp_host_port.sv ====
`timescale 1ns/1ps
// Functional notes
// - Drive data only during host or DMA reads.
// - Low read strobe requests a read.
// - Low write strobe requests a write.
// - Latch address on the strobe's leading edge.
// - Raise DMA request for one byte transfer.
// - Last byte: drop request on grant fall.
// - Low grant enables the DMA data path.
// - Terminal count counts only while grant low.
// - Core interrupt request appears on output pin.
// - Register strobes answered only while chip select low; granted DMA strobes ignore it.
// - Device reset clears operating state, keeps config.
module fhp_host_port #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 3
) (
  input  wire logic                            SYS_CLK_IN,
  input  wire logic                            RST_N_IN,
  input  wire logic                            DEV_RESET_IN,
  input  wire logic                            CHIP_SELECT_N_IN,
  input  wire logic                            HOST_READ_STROBE_N_IN,
  input  wire logic                            HOST_WRITE_STROBE_N_IN,
  input  wire logic [fhp_pkg::FHP_ADDR_W-1:0]  LOCAL_REG_ADDR_IN,
  input  wire logic [fhp_pkg::FHP_DATA_W-1:0]  HOST_DATA_BUS_IN,
  output logic      [fhp_pkg::FHP_DATA_W-1:0]  HOST_DATA_BUS_OUT,
  output logic                                 HOST_DATA_BUS_OE_N_OUT,
  input  wire logic                            DMA_GRANT_N_IN,
  input  wire logic                            TRANSFER_DONE_COUNT_IN,
  output logic                                 DMA_REQUEST_OUT,
  output logic                                 IRQ_OUT,
  input  wire logic                            CORE_IRQ_IN,
  input  wire logic                            CORE_DMA_NEED_IN,
  input  wire logic                            CORE_DMA_LAST_IN,
  input  wire logic [fhp_pkg::FHP_DATA_W-1:0]  CORE_REG_RDATA_IN,
  input  wire logic [fhp_pkg::FHP_DATA_W-1:0]  CORE_DMA_RDATA_IN,
  output fhp_pkg::fhp_reg_req_t                REG_REQ_OUT,
  output fhp_pkg::fhp_dma_xfer_t               DMA_XFER_OUT,
  output logic                                 OP_RESET_OUT
);
  import fhp_pkg::*;

  // Refuse widths that the carriers do not hold.
  if (DATA_W != FHP_DATA_W || ADDR_W != FHP_ADDR_W) begin : g_chk
    $error("fhp_host_port widths must match the package carriers");
  end

  logic [1:0]            rst_sync_r;
  logic                  rst_n;
  logic [FHP_EDGE_N-1:0] fall;
  logic [FHP_EDGE_N-1:0] rise;
  logic                  rd_fall;
  logic                  wr_fall;
  logic                  wr_rise;
  logic                  dack_fall;
  logic                  reg_sel;
  logic                  dma_sel;
  logic                  rd_active;
  logic [1:0]            wr_kind_r;
  logic [DATA_W-1:0]     wdata_r;
  logic                  op_rst_r;
  logic                  drq_w;
  logic                  tc_pulse_w;

  // Reset release through two flops; assertion of reset stays asynchronous.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_r <= FHP_SYNC_RST;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Leading and trailing edges of both strobes and of the DMA grant.
  fhp_edge_det #(
    .WIDTH (FHP_EDGE_N)
  ) u_edge (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (rst_n),
    .sig_n_in ({DMA_GRANT_N_IN, HOST_WRITE_STROBE_N_IN, HOST_READ_STROBE_N_IN}),
    .fall_out (fall),
    .rise_out (rise)
  );

  assign rd_fall   = fall[FHP_EDGE_RD];
  assign wr_fall   = fall[FHP_EDGE_WR];
  assign wr_rise   = rise[FHP_EDGE_WR];
  assign dack_fall = fall[FHP_EDGE_DACK];

  // A register cycle needs chip select and no grant; a granted strobe is DMA.
  assign reg_sel = ~CHIP_SELECT_N_IN & DMA_GRANT_N_IN & ~op_rst_r;
  assign dma_sel = ~DMA_GRANT_N_IN & ~op_rst_r;

  // The bus is driven for a selected register read or a granted DMA read.
  assign rd_active = ~HOST_READ_STROBE_N_IN & (reg_sel | dma_sel);

  // Device reset level, registered and handed to the core as its operating reset.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      op_rst_r     <= FHP_BIT_RST;
      OP_RESET_OUT <= FHP_BIT_RST;
    end else begin
      op_rst_r     <= DEV_RESET_IN;
      OP_RESET_OUT <= DEV_RESET_IN;
    end
  end

  // Read data and the active-low output enable, both from flops.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      HOST_DATA_BUS_OUT      <= FHP_DATA_RST;
      HOST_DATA_BUS_OE_N_OUT <= FHP_OE_N_RST;
    end else begin
      HOST_DATA_BUS_OE_N_OUT <= ~rd_active;
      if (dma_sel) begin
        HOST_DATA_BUS_OUT <= CORE_DMA_RDATA_IN;
      end else begin
        HOST_DATA_BUS_OUT <= CORE_REG_RDATA_IN;
      end
    end
  end

  // Register read pulse and the address caught on either leading edge.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      REG_REQ_OUT.rd   <= FHP_BIT_RST;
      REG_REQ_OUT.addr <= FHP_ADDR_RST;
    end else begin
      REG_REQ_OUT.rd <= rd_fall & reg_sel;
      if (rd_fall || wr_fall) begin
        REG_REQ_OUT.addr <= LOCAL_REG_ADDR_IN;
      end
    end
  end

  // The kind of write is fixed at the leading edge, so a grant change mid-cycle is harmless.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wr_kind_r <= FHP_WR_NONE;
    end else if (op_rst_r) begin
      wr_kind_r <= FHP_WR_NONE;
    end else if (wr_fall) begin
      if (dma_sel) begin
        wr_kind_r <= FHP_WR_DMA;
      end else if (reg_sel) begin
        wr_kind_r <= FHP_WR_REG;
      end else begin
        wr_kind_r <= FHP_WR_NONE;
      end
    end else if (wr_rise) begin
      wr_kind_r <= FHP_WR_NONE;
    end
  end

  // Write data is sampled while the strobe is low and used at its trailing edge.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wdata_r <= FHP_DATA_RST;
    end else if (!HOST_WRITE_STROBE_N_IN) begin
      wdata_r <= HOST_DATA_BUS_IN;
    end
  end

  // Write pulses toward the register file or the DMA path, one cycle each.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      REG_REQ_OUT.wr    <= FHP_BIT_RST;
      REG_REQ_OUT.wdata <= FHP_DATA_RST;
      DMA_XFER_OUT.wr    <= FHP_BIT_RST;
      DMA_XFER_OUT.wdata <= FHP_DATA_RST;
    end else begin
      REG_REQ_OUT.wr  <= wr_rise & (wr_kind_r == FHP_WR_REG) & ~op_rst_r;
      DMA_XFER_OUT.wr <= wr_rise & (wr_kind_r == FHP_WR_DMA) & ~op_rst_r;
      if (wr_rise) begin
        REG_REQ_OUT.wdata  <= wdata_r;
        DMA_XFER_OUT.wdata <= wdata_r;
      end
    end
  end

  // DMA read pulse on the read strobe's leading edge under a grant.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      DMA_XFER_OUT.rd <= FHP_BIT_RST;
    end else begin
      DMA_XFER_OUT.rd <= rd_fall & dma_sel;
    end
  end

  // Request handshake and terminal count qualification.
  fhp_dma_ctrl u_dma (
    .clk_in        (SYS_CLK_IN),
    .rst_n_in      (rst_n),
    .op_rst_in     (op_rst_r),
    .need_in       (CORE_DMA_NEED_IN),
    .last_in       (CORE_DMA_LAST_IN),
    .grant_n_in    (DMA_GRANT_N_IN),
    .grant_fall_in (dack_fall),
    .rd_fall_in    (rd_fall),
    .tc_in         (TRANSFER_DONE_COUNT_IN),
    .drq_out       (drq_w),
    .tc_pulse_out  (tc_pulse_w)
  );

  // Request pin and terminal count, retimed so that both come from flops here.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      DMA_REQUEST_OUT <= FHP_BIT_RST;
      DMA_XFER_OUT.tc <= FHP_BIT_RST;
    end else begin
      DMA_REQUEST_OUT <= drq_w & ~op_rst_r;
      DMA_XFER_OUT.tc <= tc_pulse_w;
    end
  end

  // Interrupt request of the core shown on the single pin.
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT <= FHP_BIT_RST;
    end else begin
      IRQ_OUT <= CORE_IRQ_IN;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!rst_n);

  AST_OE_DRIVE: assert property (
    rd_active |=> !HOST_DATA_BUS_OE_N_OUT
  ) else $error("bus not driven during a read");

  AST_OE_RELEASE: assert property (
    !rd_active |=> HOST_DATA_BUS_OE_N_OUT
  ) else $error("bus driven outside a read");

  AST_REG_RD: assert property (
    $fell(HOST_READ_STROBE_N_IN) && !CHIP_SELECT_N_IN && DMA_GRANT_N_IN && !op_rst_r
    |=> REG_REQ_OUT.rd ##1 !REG_REQ_OUT.rd
  ) else $error("register read pulse missing or too long");

  AST_REG_WR: assert property (
    REG_REQ_OUT.wr |-> $past(HOST_WRITE_STROBE_N_IN) && !$past(HOST_WRITE_STROBE_N_IN, 2)
    && REG_REQ_OUT.wdata == $past(HOST_DATA_BUS_IN, 2)
  ) else $error("register write without a trailing edge or with wrong data");

  AST_ADDR_LATCH: assert property (
    $fell(HOST_READ_STROBE_N_IN) || $fell(HOST_WRITE_STROBE_N_IN)
    |=> REG_REQ_OUT.addr == $past(LOCAL_REG_ADDR_IN)
  ) else $error("address not caught on the leading edge");

  AST_ADDR_HOLD: assert property (
    !HOST_READ_STROBE_N_IN && !$fell(HOST_READ_STROBE_N_IN) && HOST_WRITE_STROBE_N_IN
    |=> $stable(REG_REQ_OUT.addr)
  ) else $error("address changed inside a read cycle");

  AST_DMA_RD: assert property (
    $fell(HOST_READ_STROBE_N_IN) && !DMA_GRANT_N_IN && !op_rst_r |=> DMA_XFER_OUT.rd
  ) else $error("granted read did not move a DMA byte");

  AST_TC_PIN: assert property (
    DMA_XFER_OUT.tc |-> !$past(DMA_GRANT_N_IN, 2)
  ) else $error("terminal count taken while grant high");

  AST_IRQ: assert property (
    ##1 IRQ_OUT == $past(CORE_IRQ_IN)
  ) else $error("interrupt pin does not follow the core");

  AST_CS_GATE: assert property (
    REG_REQ_OUT.rd |-> !$past(CHIP_SELECT_N_IN)
  ) else $error("register read without chip select");

  AST_OP_RESET: assert property (
    DEV_RESET_IN ##1 DEV_RESET_IN |=> OP_RESET_OUT && !DMA_REQUEST_OUT && !REG_REQ_OUT.rd
  ) else $error("device reset did not quiet the port");

  AST_DMA_NOT_REG: assert property (
    REG_REQ_OUT.rd |-> $past(DMA_GRANT_N_IN)
  ) else $error("register read taken under a DMA grant");

  AST_DRQ_LAST: assert property (
    DMA_REQUEST_OUT && CORE_DMA_LAST_IN && $fell(DMA_GRANT_N_IN) && !op_rst_r
    |=> ##1 !DMA_REQUEST_OUT
  ) else $error("request still high after the last byte grant");

  COV_REG_READ: cover property (REG_REQ_OUT.rd ##[1:8] HOST_DATA_BUS_OE_N_OUT);
  COV_REG_WRITE: cover property (REG_REQ_OUT.wr);
  COV_DMA_TC: cover property (DMA_XFER_OUT.rd ##[1:20] DMA_XFER_OUT.tc);
  COV_DRQ_CYCLE: cover property (DMA_REQUEST_OUT ##[1:20] !DMA_REQUEST_OUT);

endmodule

// ==== tb/fhp_host_model.sv ====
`timescale 1ns/1ps
// Host processor and DMA controller on the far side of the port; drives at the falling edge.
module fhp_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_n_in,
  output logic      [7:0] bus_out,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic      [2:0] addr_out,
  output logic            grant_n_out,
  output logic            tc_out
);
  logic [7:0] host_data;
  logic       host_drv;
  logic [7:0] last_bus;

  // Wire level; an undriven bus shows a changing pattern, never the last value.
  always_comb begin
    if (!dev_oe_n_in) begin
      bus_out = dev_data_in;
    end else if (host_drv) begin
      bus_out = host_data;
    end else begin
      bus_out = ~last_bus;
    end
  end

  // Remembers the wire level so that a released bus differs from it.
  always @(posedge clk_in) begin
    last_bus <= bus_out;
  end

  // Idle bus at time zero.
  initial begin
    {cs_n_out, rd_n_out, wr_n_out, grant_n_out} = 4'hF;
    {tc_out, host_drv, addr_out, host_data, last_bus} = '0;
  end

  // Strobe cycle of three clocks; the address moves after the leading edge.
  task automatic cycle(input logic wr, input logic cs_n, input logic [2:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clk_in);
    addr_out  = a;
    cs_n_out  = cs_n;
    host_drv  = wr;
    host_data = wd;
    rd_n_out  = wr;
    wr_n_out  = !wr;
    @(negedge clk_in);
    addr_out = ~a;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rd = bus_out;
    {rd_n_out, wr_n_out, cs_n_out, host_drv} = 4'hE;
  endtask

  // Sets the grant level for DMA cycles.
  task automatic set_grant(input logic v);
    @(negedge clk_in);
    grant_n_out = v;
  endtask

  // Terminal count pulse of one clock.
  task automatic pulse_tc();
    @(negedge clk_in);
    tc_out = 1'b1;
    @(negedge clk_in);
    tc_out = 1'b0;
  endtask
endmodule

// ==== tb/fhp_host_port_bench.sv ====
`timescale 1ns/1ps
// Self-checking bench for the host bus and DMA port.
module fhp_host_port_bench;
  import fhp_pkg::*;
  logic          clk;
  logic          rst_n;
  logic          dev_rst;
  logic          irq_core;
  logic          need;
  logic          last;
  logic [7:0]    dma_rdata;
  logic [7:0]    reg_rdata;
  logic [7:0]    bus;
  logic [7:0]    dout;
  logic [7:0]    d;
  logic          cs_n;
  logic          rd_n;
  logic          wr_n;
  logic          grant_n;
  logic          tc;
  logic          oe_n;
  logic          dma_request;
  logic          irq;
  logic          op_rst;
  logic [2:0]    addr;
  logic [5:0]    ev;
  fhp_reg_req_t  reg_req;
  fhp_dma_xfer_t dma_xfer;
  int            fail_count;
  int            checks_done;
  int            cycles;
  int            cnt [6];
  int            base [6];

  // Clock of 40 ns.
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Core register data depends on the latched address.
  assign reg_rdata = {5'h14, reg_req.addr};
  assign ev = {~oe_n, dma_xfer.tc, dma_xfer.wr, dma_xfer.rd, reg_req.wr, reg_req.rd};

  fhp_host_port dut (
    .SYS_CLK_IN             (clk),
    .RST_N_IN               (rst_n),
    .DEV_RESET_IN           (dev_rst),
    .CHIP_SELECT_N_IN       (cs_n),
    .HOST_READ_STROBE_N_IN  (rd_n),
    .HOST_WRITE_STROBE_N_IN (wr_n),
    .LOCAL_REG_ADDR_IN      (addr),
    .HOST_DATA_BUS_IN       (bus),
    .HOST_DATA_BUS_OUT      (dout),
    .HOST_DATA_BUS_OE_N_OUT (oe_n),
    .DMA_GRANT_N_IN         (grant_n),
    .TRANSFER_DONE_COUNT_IN (tc),
    .DMA_REQUEST_OUT        (dma_request),
    .IRQ_OUT                (irq),
    .CORE_IRQ_IN            (irq_core),
    .CORE_DMA_NEED_IN       (need),
    .CORE_DMA_LAST_IN       (last),
    .CORE_REG_RDATA_IN      (reg_rdata),
    .CORE_DMA_RDATA_IN      (dma_rdata),
    .REG_REQ_OUT            (reg_req),
    .DMA_XFER_OUT           (dma_xfer),
    .OP_RESET_OUT           (op_rst)
  );

  fhp_host_model host (
    .clk_in      (clk),
    .dev_data_in (dout),
    .dev_oe_n_in (oe_n),
    .bus_out     (bus),
    .cs_n_out    (cs_n),
    .rd_n_out    (rd_n),
    .wr_n_out    (wr_n),
    .addr_out    (addr),
    .grant_n_out (grant_n),
    .tc_out      (tc)
  );

  // Counts pulses and driven-bus cycles, and cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < 6; i++) begin
      if (ev[i] === 1'b1) begin
        cnt[i]++;
      end
    end
    if (cycles == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic mark();
    base = cnt;
  endtask

  function automatic int delta(input int i);
    return cnt[i] - base[i];
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reads and writes every register address.
  task automatic t_reg();
    logic [7:0] wd;
    for (int a = 0; a < 8; a++) begin
      mark();
      host.cycle(1'b0, 1'b0, 3'(a), 8'h00, d);
      wait_n(2);
      chk(d === {5'h14, 3'(a)}, "register read data");
      chk(delta(0) == 1 && delta(5) == 3 && oe_n === 1'b1, "read pulse or drive");
      wd = 8'h3C ^ 8'(a);
      mark();
      host.cycle(1'b1, 1'b0, 3'(a), wd, d);
      wait_n(2);
      chk(delta(1) == 1 && delta(5) == 0, "write pulse or drive");
      chk(reg_req.addr === 3'(a) && reg_req.wdata === wd, "write address or data");
    end
  endtask

  // Strobes without chip select are ignored.
  task automatic t_cs();
    mark();
    host.cycle(1'b0, 1'b1, 3'h2, 8'h00, d);
    host.cycle(1'b1, 1'b1, 3'h6, 8'hA5, d);
    wait_n(2);
    chk(delta(0) + delta(1) + delta(5) == 0, "access without select");
  endtask

  // DMA bytes, terminal count and both ways of clearing the request.
  task automatic t_dma();
    need = 1'b1;
    wait_n(3);
    chk(dma_request === 1'b1, "request not raised");
    host.set_grant(1'b0);
    // Two granted reads in a row, the core offering a new byte for each.
    for (int k = 0; k < 2; k++) begin
      dma_rdata = 8'h5C + 8'(k);
      mark();
      host.cycle(1'b0, 1'b1, 3'h1, 8'h00, d);
      wait_n(2);
      chk(d === 8'h5C + 8'(k) && delta(2) == 1 && delta(0) == 0, "dma read");
    end
    mark();
    host.cycle(1'b1, 1'b1, 3'h1, 8'hC3, d);
    wait_n(2);
    chk(dma_xfer.wdata === 8'hC3 && delta(3) == 1 && delta(1) == 0, "dma write");
    mark();
    host.pulse_tc();
    wait_n(3);
    chk(delta(4) == 1 && dma_request === 1'b1, "count under grant");
    host.set_grant(1'b1);
    mark();
    host.pulse_tc();
    wait_n(3);
    chk(delta(4) == 0, "count without grant");
    last = 1'b1;
    host.set_grant(1'b0);
    wait_n(3);
    chk(dma_request === 1'b0, "last byte grant clear");
    host.set_grant(1'b1);
    wait_n(4);
    chk(dma_request === 1'b0, "request came back");
    need = 1'b0;
    last = 1'b0;
    host.set_grant(1'b0);
    need = 1'b1;
    wait_n(3);
    chk(dma_request === 1'b1, "demand request");
    last = 1'b1;
    host.cycle(1'b0, 1'b1, 3'h0, 8'h00, d);
    chk(dma_request === 1'b0 && d === 8'h5D, "demand read clear");
    host.set_grant(1'b1);
    need = 1'b0;
    last = 1'b0;
  endtask

  // Interrupt follows the core one cycle late.
  task automatic t_irq();
    @(negedge clk);
    irq_core = 1'b1;
    @(negedge clk);
    chk(irq === 1'b1, "interrupt set");
    irq_core = 1'b0;
    @(negedge clk);
    chk(irq === 1'b0, "interrupt clear");
  endtask

  // Device reset drops the request and blocks accesses.
  task automatic t_devrst();
    need = 1'b1;
    wait_n(3);
    dev_rst = 1'b1;
    wait_n(4);
    chk(dma_request === 1'b0 && op_rst === 1'b1 && oe_n === 1'b1, "device reset");
    mark();
    host.cycle(1'b0, 1'b0, 3'h4, 8'h00, d);
    chk(delta(0) == 0 && delta(5) == 0, "access in device reset");
    dev_rst = 1'b0;
    wait_n(6);
    chk(op_rst === 1'b0 && dma_request === 1'b1, "device reset release");
    need = 1'b0;
  endtask

  // Main sequence.
  initial begin
    rst_n     = 1'b0;
    dev_rst   = 1'b0;
    irq_core  = 1'b0;
    need      = 1'b0;
    last      = 1'b0;
    wait_n(10);
    chk(oe_n === 1'b1 && dma_request === 1'b0 && irq === 1'b0, "outputs in reset");
    rst_n = 1'b1;
    wait_n(4);
    t_reg();
    t_cs();
    t_dma();
    t_irq();
    t_devrst();
    finish_test();
  end
endmodule
